// ===== shared/ptsu_regs.vh
// Register offsets, field positions and timing constants of the time stamp unit.
// Assumes a 32-bit AHB-Lite slave port and a 50 MHz system clock.
`ifndef PTSU_REGS_VH
`define PTSU_REGS_VH
`define PTSU_A_TXSTAMP   8'h00
`define PTSU_A_ADVANCE   8'h04
`define PTSU_A_STATUS    8'h08
`define PTSU_A_REL_UP    8'h0c
`define PTSU_A_REL_LO    8'h10
`define PTSU_A_PORT_DIS  8'h14
`define PTSU_A_RATE_CFG  8'h18
`define PTSU_A_PIN_FUNC  8'h1c
`define PTSU_A_IRQ_MASK  8'h20
`define PTSU_A_TOD_NS    8'h24
`define PTSU_A_TOD_SECL  8'h28
`define PTSU_A_TOD_SECH  8'h2c
`define PTSU_A_LS_BASE   8'h40
`define PTSU_A_LS_END    8'hc0
`define PTSU_LS_STRIDE   3'd5
`define PTSU_LS_CTRL     3'd0
`define PTSU_LS_SECL     3'd1
`define PTSU_LS_SECH     3'd2
`define PTSU_LS_NSEC     3'd3
`define PTSU_LS_WFH      3'd4
`define PTSU_LS_WFL      3'd5
`define PTSU_ACT_LOAD    2'h0
`define PTSU_ACT_DELTA   2'h1
`define PTSU_ACT_STORE   2'h2
`define PTSU_ACT_CLOCK   2'h3
`define PTSU_CTRL_SYNC   2
`define PTSU_CTRL_INV    3
`define PTSU_CTRL_ARM    4
`define PTSU_ST_VALID    0
`define PTSU_ST_OVFL     11
`define PTSU_ADV_CLROVF  31
`define PTSU_RATE_EN     31
`define PTSU_RATE_MINUS  30
`define PTSU_OP_ONESTEP  3'h2
`define PTSU_OP_TWOSTEP  3'h3
`define PTSU_OP_ORIGIN   3'h5
`define PTSU_CLK_MHZ     50
`define PTSU_NOM_NS      30'd20
`define PTSU_NS_PER_SEC  30'd1000000000
`define PTSU_Q_DEPTH     8'h80
`define PTSU_ID_NONE     6'h3f
`define PTSU_ID_FIRST    6'h04
`endif

// ===== core/ptsu_top.v
// Time stamp unit: time of day counter, four pin load/store controllers,
// shared two-step transmit stamp queue and identifier allocator.
// Assumes MAC and classifier logic on hclk; timing pins are asynchronous.
// Function
// - Capture a 48-bit receive stamp at each frame start from the MAC.
// - Opcode 2 corrects residence, 3 queues transmit time, 5 writes origin time.
// - Time advances each cycle by nominal period plus zero, one or minus one.
// - Rate adjust adds or drops one nanosecond at a programmed interval.
// - Four identical controllers, each tied to its own overlaid timing pin.
// - Load writes controller time into the counter; store captures current time.
// - Delta command adds controller nanoseconds to current time instead.
// - Sync makes load or store wait for pin edge, else immediate.
// - Clock action drives programmed high and low periods; sync gives one pulse.
// - Pulse high field is duration, low field is delay after nanosecond wrap.
// - Inverse polarity uses falling edges for detection and generation.
// - Each controller holds 48-bit seconds and 30-bit nanoseconds.
// - Every executed operation raises a maskable interrupt; clock at the start of each active level.
// - Queued two-step stamps of all ports go into one shared 128-entry FIFO.
// - Entry holds valid flag, 6-bit identifier, egress port and stamp.
// - Multicast frames give one entry per port with the same identifier.
// - Stamp arriving at full queue is dropped and sets sticky overflow flag.
// - Head readable through status and stamp; any advance write drops head.
// - Two-step stamps for frames to CPU extraction make no queue entry.
// - Identifiers 0 to 63; 0 to 3 reserved; 63 when none free.
// - Per-port disable suppresses two-step stamping, overriding the classifier.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ptsu_regs.vh"
module ptsu_top (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	input  wire        rx_frame_start,
	output reg  [47:0] rx_stamp_q,
	input  wire        id_alloc_req,
	output reg  [5:0]  id_alloc_q,
	input  wire        tx_frame_start,
	input  wire [2:0]  rewrite_operation_code,
	input  wire [5:0]  stamp_identifier,
	input  wire [3:0]  egress_port_number,
	input  wire        egress_to_cpu,
	input  wire [29:0] frame_rx_ns,
	output reg  [29:0] residence_ns_q,
	output reg         residence_vld_q,
	output reg  [47:0] origin_sec_q,
	output reg  [29:0] origin_ns_q,
	output reg         origin_vld_q,
	input  wire [3:0]  timing_pin_in,
	output reg  [3:0]  timing_pin_out,
	output reg  [3:0]  timing_pin_oen_n,
	output reg  [3:0]  ls_irq_q
);
	// Adds a nanosecond increment with wrap at one second; bit 31 is the carry.
	function [31:0] ptsu_ns_add;
		input [29:0] a;
		input [30:0] b;
		reg   [30:0] s;
		begin
			s = {1'b0, a} + b;
			if (s >= `PTSU_NS_PER_SEC)
				ptsu_ns_add = {1'b1, s - `PTSU_NS_PER_SEC};
			else
				ptsu_ns_add = {1'b0, s};
		end
	endfunction

	// Controller window decode; bit 2 flags a hit and bits 1:0 give the controller.
	function [2:0] ptsu_ls_dec;
		input [7:0] a;
		reg   [7:0] o;
		begin
			o = a - `PTSU_A_LS_BASE;
			ptsu_ls_dec = {(a >= `PTSU_A_LS_BASE) && (a < `PTSU_A_LS_END), o[6:5]};
		end
	endfunction

	reg  [47:0] time_seconds_value_q, time_seconds_value_d;
	reg  [29:0] tod_ns_q, tod_ns_d;
	reg  [31:0] rate_cfg_q, rate_cnt_q;
	reg  [15:0] port_dis_q;
	reg  [3:0]  pin_func_q, irq_mask_q;
	reg  [4:0]  ls_ctrl_q [0:3];
	reg  [47:0] ls_sec_q [0:3];
	reg  [29:0] ls_ns_q [0:3];
	reg  [29:0] ls_wfh_q [0:3];
	reg  [29:0] ls_wfl_q [0:3];
	reg  [29:0] ls_acc_q [0:3];
	reg  [3:0]  wave_q, pin_s1_q, pin_s2_q, pin_s3_q;
	reg  [3:0]  ls_exec, pulse_win, wave_d;
	reg  [5:0]  q_id [0:127];
	reg  [3:0]  q_port [0:127];
	reg  [31:0] q_stamp [0:127];
	reg  [6:0]  q_wr_q, q_rd_q;
	reg  [7:0]  q_cnt_q;
	reg         q_ovfl_q;
	reg  [63:0] id_used_q;
	reg  [5:0]  id_free;
	reg         wr_pend_q, rd_pend_q;
	reg  [7:0]  wr_addr_q, rd_addr_q;
	reg  [31:0] rd_mux, ns_sum;
	reg  [30:0] inc;
	integer     i, j, k, m;
	wire        bus_take = hsel & hready & htrans[1];
	wire        bus_wr = wr_pend_q;
	wire        q_push = tx_frame_start & (rewrite_operation_code == `PTSU_OP_TWOSTEP)
		& ~egress_to_cpu & ~port_dis_q[egress_port_number];
	wire        q_full = (q_cnt_q == `PTSU_Q_DEPTH);
	wire        q_empty = (q_cnt_q == 8'h00);
	wire        q_pop = bus_wr & (wr_addr_q == `PTSU_A_ADVANCE) & ~q_empty;
	wire        rate_hit = rate_cfg_q[`PTSU_RATE_EN] & (rate_cnt_q[29:0] >= rate_cfg_q[29:0]);
	wire [2:0]  ls_sel = wr_addr_q[4:2];
	wire [2:0]  ls_wdec = ptsu_ls_dec(wr_addr_q);
	wire [2:0]  ls_rdec = ptsu_ls_dec(rd_addr_q);
	wire [1:0]  ls_idx = ls_wdec[1:0];
	wire        ls_wr = bus_wr & ls_wdec[2] & (ls_sel <= `PTSU_LS_WFL);

	// Lowest free identifier above the reserved ones; all busy gives the marker value.
	always @*
	begin
		id_free = `PTSU_ID_NONE;
		for (j = `PTSU_ID_NONE - 1; j >= `PTSU_ID_FIRST; j = j - 1)
			if (!id_used_q[j])
				id_free = j[5:0];
	end

	// Controller trigger: immediate, or on the selected pin edge when synced.
	always @*
	begin
		for (k = 0; k < 4; k = k + 1)
		begin
			ls_exec[k] = ls_ctrl_q[k][`PTSU_CTRL_ARM] & pin_func_q[k]
				& (ls_ctrl_q[k][1:0] != `PTSU_ACT_CLOCK)
				& (~ls_ctrl_q[k][`PTSU_CTRL_SYNC]
				| (ls_ctrl_q[k][`PTSU_CTRL_INV] ? (pin_s3_q[k] & ~pin_s2_q[k])
				: (~pin_s3_q[k] & pin_s2_q[k])));
			pulse_win[k] = (tod_ns_q >= ls_wfl_q[k])
				& ({1'b0, tod_ns_q} < {1'b0, ls_wfl_q[k]} + {1'b0, ls_wfh_q[k]});
			if (ls_ctrl_q[k][`PTSU_CTRL_SYNC])
				wave_d[k] = pulse_win[k];
			else if ({1'b0, ls_acc_q[k]} + {1'b0, `PTSU_NOM_NS}
				>= {1'b0, wave_q[k] ? ls_wfh_q[k] : ls_wfl_q[k]})
				wave_d[k] = ~wave_q[k];
			else
				wave_d[k] = wave_q[k];
		end
	end

	// Next time of day: nominal step with rate correction, then controller overrides.
	always @*
	begin
		inc = {1'b0, `PTSU_NOM_NS};
		if (rate_hit)
			inc = rate_cfg_q[`PTSU_RATE_MINUS] ? inc - 31'd1 : inc + 31'd1;
		ns_sum = ptsu_ns_add(tod_ns_q, inc);
		tod_ns_d = ns_sum[29:0];
		time_seconds_value_d = time_seconds_value_q + {47'h0, ns_sum[31]};
		for (m = 3; m >= 0; m = m - 1)
		begin
			if (ls_exec[m] && ls_ctrl_q[m][1:0] == `PTSU_ACT_LOAD)
			begin
				tod_ns_d = ls_ns_q[m];
				time_seconds_value_d = ls_sec_q[m];
			end
			else if (ls_exec[m] && ls_ctrl_q[m][1:0] == `PTSU_ACT_DELTA)
			begin
				ns_sum = ptsu_ns_add(tod_ns_q, {1'b0, ls_ns_q[m]});
				tod_ns_d = ns_sum[29:0];
				time_seconds_value_d = time_seconds_value_q + {47'h0, ns_sum[31]};
			end
		end
	end

	// Register read data.
	always @*
	begin
		rd_mux = 32'h0;
		case (rd_addr_q)
		`PTSU_A_TXSTAMP:
			rd_mux = q_empty ? 32'h0 : q_stamp[q_rd_q];
		`PTSU_A_STATUS:
			rd_mux = {20'h0, q_ovfl_q, q_empty ? 11'h0
				: {q_port[q_rd_q], q_id[q_rd_q], 1'b1}};
		`PTSU_A_PORT_DIS:
			rd_mux = {16'h0, port_dis_q};
		`PTSU_A_RATE_CFG:
			rd_mux = rate_cfg_q;
		`PTSU_A_PIN_FUNC:
			rd_mux = {28'h0, pin_func_q};
		`PTSU_A_IRQ_MASK:
			rd_mux = {28'h0, irq_mask_q};
		`PTSU_A_TOD_NS:
			rd_mux = {2'h0, tod_ns_q};
		`PTSU_A_TOD_SECL:
			rd_mux = time_seconds_value_q[31:0];
		`PTSU_A_TOD_SECH:
			rd_mux = {16'h0, time_seconds_value_q[47:32]};
		default:
			if (ls_rdec[2])
				case (rd_addr_q[4:2])
				`PTSU_LS_CTRL:
					rd_mux = {27'h0, ls_ctrl_q[ls_rdec[1:0]]};
				`PTSU_LS_SECL:
					rd_mux = ls_sec_q[ls_rdec[1:0]][31:0];
				`PTSU_LS_SECH:
					rd_mux = {16'h0, ls_sec_q[ls_rdec[1:0]][47:32]};
				`PTSU_LS_NSEC:
					rd_mux = {2'h0, ls_ns_q[ls_rdec[1:0]]};
				`PTSU_LS_WFH:
					rd_mux = {2'h0, ls_wfh_q[ls_rdec[1:0]]};
				`PTSU_LS_WFL:
					rd_mux = {2'h0, ls_wfl_q[ls_rdec[1:0]]};
				default:
					rd_mux = 32'h0;
				endcase
		endcase
	end

	// Queue storage carries no reset; only pointers and count decide validity.
	always @(posedge hclk)
	begin
		if (q_push && !q_full)
		begin
			q_id[q_wr_q] <= stamp_identifier;
			q_port[q_wr_q] <= egress_port_number;
			q_stamp[q_wr_q] <= {time_seconds_value_q[1:0], tod_ns_q};
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hrdata <= 32'h0;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_addr_q <= 8'h0;
			rd_addr_q <= 8'h0;
			time_seconds_value_q <= 48'h0;
			tod_ns_q <= 30'h0;
			rate_cfg_q <= 32'h0;
			rate_cnt_q <= 32'h0;
			port_dis_q <= 16'h0;
			pin_func_q <= 4'h0;
			irq_mask_q <= 4'h0;
			q_wr_q <= 7'h0;
			q_rd_q <= 7'h0;
			q_cnt_q <= 8'h0;
			q_ovfl_q <= 1'b0;
			id_used_q <= 64'hf;
			id_alloc_q <= 6'h0;
			rx_stamp_q <= 48'h0;
			residence_ns_q <= 30'h0;
			residence_vld_q <= 1'b0;
			origin_sec_q <= 48'h0;
			origin_ns_q <= 30'h0;
			origin_vld_q <= 1'b0;
			timing_pin_out <= 4'h0;
			timing_pin_oen_n <= 4'hf;
			ls_irq_q <= 4'h0;
			wave_q <= 4'h0;
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			pin_s3_q <= 4'h0;
			for (i = 0; i < 4; i = i + 1)
			begin
				ls_ctrl_q[i] <= 5'h0;
				ls_sec_q[i] <= 48'h0;
				ls_ns_q[i] <= 30'h0;
				ls_wfh_q[i] <= 30'h0;
				ls_wfl_q[i] <= 30'h0;
				ls_acc_q[i] <= 30'h0;
			end
		end
		else
		begin
			// Reads take one wait state so a write just before is already visible.
			wr_pend_q <= bus_take & hwrite;
			rd_pend_q <= bus_take & ~hwrite;
			if (bus_take)
			begin
				wr_addr_q <= haddr[7:0];
				rd_addr_q <= haddr[7:0];
			end
			hreadyout <= ~(bus_take & ~hwrite);
			if (rd_pend_q)
				hrdata <= rd_mux;
			time_seconds_value_q <= time_seconds_value_d;
			tod_ns_q <= tod_ns_d;
			rate_cnt_q <= rate_hit ? 32'h0 : rate_cnt_q + 32'h1;
			rx_stamp_q <= rx_frame_start ? {time_seconds_value_q[17:0], tod_ns_q} : rx_stamp_q;
			residence_vld_q <= tx_frame_start & (rewrite_operation_code == `PTSU_OP_ONESTEP);
			if (tx_frame_start && rewrite_operation_code == `PTSU_OP_ONESTEP)
				residence_ns_q <= (tod_ns_q >= frame_rx_ns) ? tod_ns_q - frame_rx_ns
					: tod_ns_q + (`PTSU_NS_PER_SEC - frame_rx_ns);
			origin_vld_q <= tx_frame_start & (rewrite_operation_code == `PTSU_OP_ORIGIN);
			if (tx_frame_start && rewrite_operation_code == `PTSU_OP_ORIGIN)
			begin
				origin_sec_q <= time_seconds_value_q;
				origin_ns_q <= tod_ns_q;
			end
			if (q_push && !q_full)
				q_wr_q <= q_wr_q + 7'h1;
			if (q_pop)
				q_rd_q <= q_rd_q + 7'h1;
			q_cnt_q <= q_cnt_q + {7'h0, q_push & ~q_full} - {7'h0, q_pop};
			// Overflow set wins over a clear in the same cycle.
			if (q_push && q_full)
				q_ovfl_q <= 1'b1;
			else if (bus_wr && wr_addr_q == `PTSU_A_ADVANCE && hwdata[`PTSU_ADV_CLROVF])
				q_ovfl_q <= 1'b0;
			// Allocation set wins over a software release of the same bit.
			for (i = `PTSU_ID_FIRST; i < `PTSU_ID_NONE; i = i + 1)
				if (id_alloc_req && id_free == i[5:0])
					id_used_q[i] <= 1'b1;
				else if (bus_wr && wr_addr_q == `PTSU_A_REL_LO && !i[5] && hwdata[i[4:0]])
					id_used_q[i] <= 1'b0;
				else if (bus_wr && wr_addr_q == `PTSU_A_REL_UP && i[5] && hwdata[i[4:0]])
					id_used_q[i] <= 1'b0;
			if (id_alloc_req)
				id_alloc_q <= id_free;
			if (bus_wr && wr_addr_q == `PTSU_A_PORT_DIS)
				port_dis_q <= hwdata[15:0];
			if (bus_wr && wr_addr_q == `PTSU_A_RATE_CFG)
				rate_cfg_q <= hwdata;
			if (bus_wr && wr_addr_q == `PTSU_A_PIN_FUNC)
				pin_func_q <= hwdata[3:0];
			if (bus_wr && wr_addr_q == `PTSU_A_IRQ_MASK)
				irq_mask_q <= hwdata[3:0];
			// The first synchroniser stage feeds only the second.
			pin_s1_q <= timing_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (i = 0; i < 4; i = i + 1)
			begin
				if (ls_exec[i] && ls_ctrl_q[i][1:0] == `PTSU_ACT_STORE)
				begin
					ls_sec_q[i] <= time_seconds_value_q;
					ls_ns_q[i] <= tod_ns_q;
				end
				else if (ls_wr && ls_idx == i[1:0] && ls_sel == `PTSU_LS_SECL)
					ls_sec_q[i][31:0] <= hwdata;
				else if (ls_wr && ls_idx == i[1:0] && ls_sel == `PTSU_LS_SECH)
					ls_sec_q[i][47:32] <= hwdata[15:0];
				else if (ls_wr && ls_idx == i[1:0] && ls_sel == `PTSU_LS_NSEC)
					ls_ns_q[i] <= hwdata[29:0];
				if (ls_wr && ls_idx == i[1:0] && ls_sel == `PTSU_LS_WFH)
					ls_wfh_q[i] <= hwdata[29:0];
				if (ls_wr && ls_idx == i[1:0] && ls_sel == `PTSU_LS_WFL)
					ls_wfl_q[i] <= hwdata[29:0];
				if (ls_wr && ls_idx == i[1:0] && ls_sel == `PTSU_LS_CTRL)
					ls_ctrl_q[i] <= hwdata[4:0];
				else if (ls_exec[i] || (ls_ctrl_q[i][`PTSU_CTRL_SYNC] && wave_q[i]
					&& !wave_d[i] && ls_ctrl_q[i][1:0] == `PTSU_ACT_CLOCK))
					ls_ctrl_q[i][`PTSU_CTRL_ARM] <= 1'b0;
				if (ls_ctrl_q[i][`PTSU_CTRL_ARM] && ls_ctrl_q[i][1:0] == `PTSU_ACT_CLOCK
					&& pin_func_q[i])
				begin
					wave_q[i] <= wave_d[i];
					ls_acc_q[i] <= (wave_d[i] != wave_q[i]) ? 30'h0
						: ls_acc_q[i] + `PTSU_NOM_NS;
				end
				else
				begin
					wave_q[i] <= 1'b0;
					ls_acc_q[i] <= 30'h0;
				end
				timing_pin_out[i] <= wave_q[i] ^ ls_ctrl_q[i][`PTSU_CTRL_INV];
				timing_pin_oen_n[i] <= ~(pin_func_q[i]
					& (ls_ctrl_q[i][1:0] == `PTSU_ACT_CLOCK));
				ls_irq_q[i] <= irq_mask_q[i] & (ls_exec[i] | (wave_d[i] & ~wave_q[i]
					& ls_ctrl_q[i][`PTSU_CTRL_ARM]
					& (ls_ctrl_q[i][1:0] == `PTSU_ACT_CLOCK)));
			end
		end
	end
endmodule // ptsu_top

// ===== verif/ptsu_top_sva.sv
// Concurrent checks on the bus handshake and stamp outputs of the time stamp unit.
// Assumes binding to ptsu_top, one clock hclk and the async low reset hresetn.
`timescale 1ns/1ps
module ptsu_top_chk (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire        tx_frame_start,
	input wire [2:0]  rewrite_operation_code,
	input wire        id_alloc_req,
	input wire [5:0]  id_alloc_q,
	input wire        residence_vld_q,
	input wire        origin_vld_q,
	input wire [29:0] origin_ns_q
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("hresp not OKAY");
	property p_rd_wait;
		hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_nowait;
		hsel && hready && htrans[1] && hwrite |=> hreadyout;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_one_wait;
		!hreadyout |=> hreadyout;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
	property p_resid;
		tx_frame_start && rewrite_operation_code == 3'h2 |-> ##[1:2] residence_vld_q;
	endproperty
	a_resid: assert property (p_resid) else $error("no residence update");
	property p_origin;
		tx_frame_start && rewrite_operation_code == 3'h5 |-> ##[1:2] origin_vld_q;
	endproperty
	a_origin: assert property (p_origin) else $error("no origin update");
	property p_resid_pulse;
		residence_vld_q |=> !residence_vld_q;
	endproperty
	a_resid_pulse: assert property (p_resid_pulse) else $error("residence pulse too long");
	property p_id;
		id_alloc_req |=> id_alloc_q >= 6'h04;
	endproperty
	a_id: assert property (p_id) else $error("reserved identifier handed out");
	property p_ns;
		origin_vld_q |-> origin_ns_q < 30'd1000000000;
	endproperty
	a_ns: assert property (p_ns) else $error("origin nanoseconds out of range");
endmodule // ptsu_top_chk
bind ptsu_top ptsu_top_chk ptsu_top_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.tx_frame_start(tx_frame_start), .rewrite_operation_code(rewrite_operation_code),
	.id_alloc_req(id_alloc_req), .id_alloc_q(id_alloc_q), .residence_vld_q(residence_vld_q),
	.origin_vld_q(origin_vld_q), .origin_ns_q(origin_ns_q));

// ===== verif/ptsu_mac_model.sv
// Model of the MAC ports and classifier that feed the time stamp unit.
// Assumes hclk; fields show inverted junk between pulses so stale values never pass.
`timescale 1ns/1ps
module ptsu_mac_model (
	input wire             hclk,
	output logic           tx_frame_start,
	output logic [2:0]     rewrite_operation_code,
	output logic [5:0]     stamp_identifier,
	output logic [3:0]     egress_port_number,
	output logic           egress_to_cpu,
	output logic [29:0]    frame_rx_ns,
	output logic           id_alloc_req
);
	initial
	begin
		tx_frame_start = 1'b0;
		rewrite_operation_code = 3'h0;
		stamp_identifier = 6'h00;
		egress_port_number = 4'h0;
		egress_to_cpu = 1'b0;
		frame_rx_ns = 30'h0;
		id_alloc_req = 1'b0;
	end
	task send(input logic [2:0] op, input logic [5:0] id, input logic [3:0] pt, input logic cpu);
		@(posedge hclk);
		tx_frame_start <= 1'b1;
		rewrite_operation_code <= op;
		stamp_identifier <= id;
		egress_port_number <= pt;
		egress_to_cpu <= cpu;
		@(posedge hclk);
		tx_frame_start <= 1'b0;
		rewrite_operation_code <= ~op;
		stamp_identifier <= ~id;
		egress_port_number <= ~pt;
		egress_to_cpu <= ~cpu;
	endtask
	task alloc;
		@(posedge hclk);
		id_alloc_req <= 1'b1;
		@(posedge hclk);
		id_alloc_req <= 1'b0;
	endtask
endmodule // ptsu_mac_model

// ===== verif/test_ptsu_top.sv
// Self-checking bench for the time stamp unit over its AHB-Lite register port.
// Assumes the register map of ptsu_regs.vh and the MAC model on the stamp inputs.
`timescale 1ns/1ps
`include "ptsu_regs.vh"
module test_ptsu_top;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0]  pin = 4'h0;
	logic        rx_go = 1'b0;
	wire         hreadyout, hresp, tx_go, to_cpu, areq;
	wire [31:0]  hrdata;
	wire [2:0]   op;
	wire [5:0]   sid, aid;
	wire [3:0]   prt;
	wire [29:0]  rxns;
	wire [47:0]  rxs, osec;
	wire [3:0]   pout, poen, irq;
	int          cnt, cnt2;
	logic [31:0] r, t;
	int          n_fail = 0;
	int          n_compared = 0;
	ptsu_mac_model ptsu_mac_model_i (.hclk(hclk), .tx_frame_start(tx_go),
		.rewrite_operation_code(op), .stamp_identifier(sid), .egress_port_number(prt),
		.egress_to_cpu(to_cpu), .frame_rx_ns(rxns), .id_alloc_req(areq));
	ptsu_top ptsu_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_frame_start(rx_go),
		.rx_stamp_q(rxs), .id_alloc_req(areq), .id_alloc_q(aid), .tx_frame_start(tx_go),
		.rewrite_operation_code(op), .stamp_identifier(sid), .egress_port_number(prt),
		.egress_to_cpu(to_cpu), .frame_rx_ns(rxns), .residence_ns_q(), .residence_vld_q(),
		.origin_sec_q(osec), .origin_ns_q(), .origin_vld_q(), .timing_pin_in(pin),
		.timing_pin_out(pout), .timing_pin_oen_n(poen), .ls_irq_q(irq));
	initial
	begin
		forever #10 hclk = ~hclk;
	end
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// The slave answers in its own time, so both phases wait for hready.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task t_empty;
		bus(1'b0, 8'h3c, 32'h0);
		chk("unmapped", r, 32'h0);
		bus(1'b1, `PTSU_A_ADVANCE, 32'h0);
		bus(1'b0, `PTSU_A_STATUS, 32'h0);
		chk("empty status", r, 32'h0);
	endtask
	task t_queue;
		bus(1'b1, `PTSU_A_PORT_DIS, 32'h4);
		ptsu_mac_model_i.send(3'h3, 6'h05, 4'h1, 1'b0);
		ptsu_mac_model_i.send(3'h3, 6'h05, 4'h3, 1'b0);
		ptsu_mac_model_i.send(3'h3, 6'h06, 4'h2, 1'b0);
		ptsu_mac_model_i.send(3'h3, 6'h07, 4'h1, 1'b1);
		ptsu_mac_model_i.send(3'h2, 6'h08, 4'h1, 1'b0);
		ptsu_mac_model_i.send(3'h5, 6'h09, 4'h1, 1'b0);
		bus(1'b0, `PTSU_A_STATUS, 32'h0);
		chk("head 1", r[11:0], {1'b0, 4'h1, 6'h05, 1'b1});
		bus(1'b1, `PTSU_A_ADVANCE, 32'h0);
		bus(1'b0, `PTSU_A_STATUS, 32'h0);
		chk("head 2", r[11:0], {1'b0, 4'h3, 6'h05, 1'b1});
		bus(1'b1, `PTSU_A_ADVANCE, 32'h0);
		bus(1'b0, `PTSU_A_STATUS, 32'h0);
		chk("filtered", r[11:0], 12'h0);
		bus(1'b1, `PTSU_A_PORT_DIS, 32'h0);
	endtask
	task t_overflow;
		repeat (129) ptsu_mac_model_i.send(3'h3, 6'h04, 4'h1, 1'b0);
		bus(1'b0, `PTSU_A_STATUS, 32'h0);
		chk("full", r[11:0], {1'b1, 4'h1, 6'h04, 1'b1});
		repeat (128) bus(1'b1, `PTSU_A_ADVANCE, 32'h0);
		bus(1'b0, `PTSU_A_STATUS, 32'h0);
		chk("drained", r[11:0], 12'h800);
		bus(1'b1, `PTSU_A_ADVANCE, 32'h80000000);
		bus(1'b0, `PTSU_A_STATUS, 32'h0);
		chk("ovf cleared", r[11:0], 12'h0);
	endtask
	task t_ids;
		ptsu_mac_model_i.alloc;
		#1 chk("id first", {26'h0, aid}, 32'h4);
		ptsu_mac_model_i.alloc;
		#1 chk("id next", {26'h0, aid}, 32'h5);
		bus(1'b1, `PTSU_A_REL_LO, 32'h10);
		ptsu_mac_model_i.alloc;
		#1 chk("id reuse", {26'h0, aid}, 32'h4);
	endtask
	// Back-to-back reads sample the counter four cycles apart, so the step is four periods.
	task t_rate(input logic [31:0] cfg, input logic [31:0] step);
		bus(1'b1, `PTSU_A_RATE_CFG, cfg);
		bus(1'b0, `PTSU_A_TOD_NS, 32'h0);
		t = r;
		bus(1'b0, `PTSU_A_TOD_NS, 32'h0);
		chk("tod step", r - t, step);
	endtask
	task t_ctrl;
		bus(1'b1, `PTSU_A_PIN_FUNC, 32'h1);
		bus(1'b1, 8'h44, 32'h7);
		bus(1'b1, 8'h48, 32'h0);
		bus(1'b1, 8'h4c, 32'h0);
		bus(1'b1, 8'h40, 32'h10);
		bus(1'b0, `PTSU_A_TOD_SECL, 32'h0);
		chk("loaded sec", r, 32'h7);
		ptsu_mac_model_i.send(3'h5, 6'h09, 4'h1, 1'b0);
		#1 chk("origin sec", osec[31:0], 32'h7);
		bus(1'b1, 8'h44, 32'h0);
		bus(1'b1, 8'h40, 32'h12);
		bus(1'b0, 8'h44, 32'h0);
		chk("stored sec", r, 32'h7);
		bus(1'b1, 8'h40, 32'h16);
		bus(1'b0, 8'h40, 32'h0);
		chk("sync waits", r[4], 1'b1);
		pin <= 4'h1;
		repeat (6) @(posedge hclk);
		bus(1'b0, 8'h40, 32'h0);
		chk("sync ran", r[4], 1'b0);
		bus(1'b1, 8'h40, 32'h1e);
		pin <= 4'h0;
		repeat (6) @(posedge hclk);
		bus(1'b0, 8'h40, 32'h0);
		chk("falling ran", r[4], 1'b0);
	endtask
	// The stamp is taken three cycles before the read samples the counter.
	task t_rx;
		rx_go <= 1'b1;
		@(posedge hclk);
		rx_go <= 1'b0;
		bus(1'b0, `PTSU_A_TOD_NS, 32'h0);
		chk("rx stamp", {2'h0, rxs[29:0]}, r - 32'd60);
		chk("rx sec", {14'h0, rxs[47:30]}, 32'h0);
	endtask
	// Forty ns high and low give one rising edge and one interrupt every four cycles.
	task t_clock;
		bus(1'b1, `PTSU_A_IRQ_MASK, 32'h1);
		bus(1'b1, 8'h50, 32'd40);
		bus(1'b1, 8'h54, 32'd40);
		bus(1'b1, 8'h40, 32'h13);
		repeat (8) @(posedge hclk);
		cnt = 0;
		cnt2 = 0;
		t[0] = pout[0];
		repeat (40)
		begin
			@(posedge hclk);
			cnt = cnt + irq[0];
			cnt2 = cnt2 + (pout[0] & ~t[0]);
			t[0] = pout[0];
		end
		chk("clock edges", cnt2, 32'd10);
		chk("clock irqs", cnt, 32'd10);
		chk("pin driven", {28'h0, poen}, 32'he);
		bus(1'b1, 8'h40, 32'h0);
		repeat (2) @(posedge hclk);
		chk("pin released", {28'h0, poen}, 32'hf);
	endtask
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_empty();
		t_rate(32'h0, 32'd80);
		t_rate(32'h80000000, 32'd84);
		t_rate(32'hc0000000, 32'd76);
		t_rate(32'h0, 32'd80);
		t_rx();
		t_queue();
		t_overflow();
		t_ids();
		t_ctrl();
		t_clock();
		summarize();
	end
	initial
	begin
		#200000;
		n_fail++;
		summarize();
	end
endmodule // test_ptsu_top
